// *** verilog/ctrl_out_defines.svh ***
// constants for the control output configuration block
// assumes a 200 MHz reference clock
`ifndef CTRL_OUT_DEFINES_SVH
`define CTRL_OUT_DEFINES_SVH
`define CLK_HZ 200000000
`define HOLD_ENTER_S 3
`define HOLD_LEAVE_S 1
`define HOLD_ENTER_CYC (`HOLD_ENTER_S * `CLK_HZ)
`define HOLD_LEAVE_CYC (`HOLD_LEAVE_S * `CLK_HZ)
`define CYCLE_TIME_RST 8'h14
`define SEC_CYC `CLK_HZ
`define MV_FULL 7'h64
`endif

// *** verilog/ctrl_out_pkg.sv ***
// types of the control output configuration block
package ctrl_out_pkg;
    typedef enum logic [3:0] {
        FN_NONE = 4'h0,
        FN_HEAT = 4'h1,
        FN_COOL = 4'h2,
        FN_ALM1 = 4'h3,
        FN_ALM2 = 4'h4,
        FN_ALM3 = 4'h5,
        FN_PEND = 4'h6,
        FN_WORK = 4'h7
    } out_fn_t;
    typedef enum logic [1:0] {
        LVL_OPER = 2'b00,
        LVL_INIT = 2'b01
    } level_t;
    typedef struct packed {
        out_fn_t primary_ctrl_route;
        out_fn_t secondary_ctrl_route;
        out_fn_t aux_route_a;
        out_fn_t aux_route_b;
        out_fn_t aux_route_c;
    } route_t;
    typedef struct packed {
        logic unit_fahr;
        logic on_off;
        logic heat_cool;
        logic direct;
    } mode_t;
endpackage

// *** verilog/cycle_pwm.sv ***
// time-proportional output over a period given in seconds
// assumes mv is a percentage 0..100 from logic on the same clock
`timescale 1ns/1ps
`include "ctrl_out_defines.svh"
module cycle_pwm #(
    parameter int SEC_CYC = `SEC_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] period_s_i,
    input wire logic [6:0] mv_i,
    output logic pwm_o
);
    // a slot must be at least one clock long
    if (SEC_CYC < 100) begin : g_bad_sec
        $error("SEC_CYC too small");
    end
    localparam int TW = $clog2(SEC_CYC + 1);
    // each second is split into 100 slots so mv maps directly to slots per second
    localparam logic [TW-1:0] SLOT = TW'(SEC_CYC / 100);
    logic [TW-1:0] tick_r;
    logic [14:0] slot_r;
    logic [14:0] slots;
    assign slots = 15'(period_s_i) * 15'd100;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_r <= '0;
            slot_r <= '0;
        end else if (tick_r >= SLOT - 1'b1) begin
            tick_r <= '0;
            // restart on expiry
            if (slot_r + 15'd1 >= slots)
                slot_r <= '0;
            else
                slot_r <= slot_r + 15'd1;
        end else begin
            tick_r <= tick_r + 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            pwm_o <= 1'b0;
        else
            pwm_o <= (slot_r < 15'(period_s_i) * 15'(mv_i));
    end
endmodule

// *** verilog/ctrl_out_cfg.sv ***
// control output configuration: levels, modes, routing and outputs
// assumes key and compare inputs come from pins, settings from same clock
// How it works
// - temperature unit is Celsius or Fahrenheit, Celsius after reset.
// - operating to setting level needs the key held three seconds.
// - setting to operating level needs the key held one second.
// - 2-PID or ON/OFF control, 2-PID after reset, no ON/OFF if positional.
// - ON/OFF reverse drives output on below set point, off above it.
// - heating and cooling periods are separate, 20 seconds after reset.
// - cooling period only applies under heating/cooling control.
// - current or linear outputs ignore the control period.
// - direct or reverse action, reverse after reset.
// - reset routes heat to out one, none to two, alarms to aux one..three.
// - heating/cooling puts cooling on out two or else on aux two.
// - aux one carries program end in place of alarm one while the pattern is on.
// - a work bit on any output counts as an alarm assigned.
// - after ON/OFF turns off, output waits for pv below sp minus hysteresis if reverse, above sp plus hysteresis if direct.
`timescale 1ns/1ps
`include "ctrl_out_defines.svh"
module ctrl_out_cfg
    import ctrl_out_pkg::*;
#(
    parameter bit HAS_SECONDARY_CTRL_ROUTE = 1'b1,
    parameter bit POSITIONAL = 1'b0,
    parameter bit PRIMARY_CTRL_ROUTE_LINEAR = 1'b0,
    parameter bit SECONDARY_CTRL_ROUTE_LINEAR = 1'b0,
    parameter int HOLD_ENTER_CYC = `HOLD_ENTER_CYC,
    parameter int HOLD_LEAVE_CYC = `HOLD_LEAVE_CYC,
    parameter int SEC_CYC = `SEC_CYC,
    parameter int PV_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic level_key_i,
    input wire logic cfg_we_i,
    input wire mode_t mode_i,
    input wire logic [7:0] heat_cycle_time_i,
    input wire logic [7:0] cool_cycle_time_i,
    input wire logic route_we_i,
    input wire route_t route_i,
    input wire logic pattern_on_i,
    input wire logic signed [PV_W-1:0] pv_i,
    input wire logic signed [PV_W-1:0] sp_i,
    input wire logic [PV_W-2:0] hyst_i,
    input wire logic [6:0] heat_mv_i,
    input wire logic [6:0] cool_mv_i,
    input wire logic [2:0] alarm_i,
    input wire logic prog_end_i,
    input wire logic [2:0] work_i,
    output level_t level_o,
    output mode_t mode_o,
    output route_t route_o,
    output logic alarm_assigned_o,
    output logic ctrl1_o,
    output logic ctrl2_o,
    output logic [2:0] aux_o
);
    // the hold counter is sized by the longer enter count
    if (HOLD_ENTER_CYC < 2 || HOLD_LEAVE_CYC < 2 ||
        HOLD_LEAVE_CYC > HOLD_ENTER_CYC) begin : g_bad_hold
        $error("hold counts out of range");
    end
    if (PV_W < 4) begin : g_bad_pv
        $error("PV_W too small");
    end
    localparam int CW = $clog2(HOLD_ENTER_CYC + 1) + 1;

    // three-stage sync, change taken when stages two and three agree
    logic [2:0] key_sync_r;
    logic key_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            key_sync_r <= '0;
            key_r <= 1'b0;
        end else begin
            key_sync_r <= {key_sync_r[1:0], level_key_i};
            if (key_sync_r[1] == key_sync_r[2])
                key_r <= key_sync_r[2];
        end
    end

    // the count must restart per press so one long hold moves only once
    logic [CW-1:0] hold_r;
    logic armed_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hold_r <= '0;
            armed_r <= 1'b1;
            level_o <= LVL_OPER;
        end else if (!key_r) begin
            hold_r <= '0;
            armed_r <= 1'b1;
        end else begin
            if (hold_r != '1)
                hold_r <= hold_r + 1'b1;
            case (level_o)
                LVL_OPER: begin
                    if (armed_r && hold_r == CW'(HOLD_ENTER_CYC - 1)) begin
                        level_o <= LVL_INIT;
                        armed_r <= 1'b0;
                    end
                end
                LVL_INIT: begin
                    if (armed_r && hold_r == CW'(HOLD_LEAVE_CYC - 1)) begin
                        level_o <= LVL_OPER;
                        armed_r <= 1'b0;
                    end
                end
                default: level_o <= LVL_OPER;
            endcase
        end
    end

    logic [7:0] heat_ct_r;
    logic [7:0] cool_ct_r;
    logic cfg_ok;
    assign cfg_ok = cfg_we_i && level_o == LVL_INIT;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // celsius, pid, standard, reverse
            mode_o <= '0;
            heat_ct_r <= `CYCLE_TIME_RST;
            cool_ct_r <= `CYCLE_TIME_RST;
        end else if (cfg_ok) begin
            mode_o.unit_fahr <= mode_i.unit_fahr;
            mode_o.on_off <= mode_i.on_off && !POSITIONAL;
            mode_o.heat_cool <= mode_i.heat_cool;
            mode_o.direct <= mode_i.direct;
            heat_ct_r <= (heat_cycle_time_i == 8'h00) ? 8'h01
                                                       : heat_cycle_time_i;
            cool_ct_r <= (cool_cycle_time_i == 8'h00) ? 8'h01
                                                       : cool_cycle_time_i;
        end
    end

    // heating/cooling change re-initialises routing; route writes otherwise
    logic hc_chg;
    assign hc_chg = cfg_ok && (mode_i.heat_cool != mode_o.heat_cool);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            route_o <= '{FN_HEAT, FN_NONE, FN_ALM1, FN_ALM2, FN_ALM3};
        end else if (hc_chg) begin
            route_o.primary_ctrl_route <= FN_HEAT;
            route_o.aux_route_a <= FN_ALM1;
            route_o.aux_route_c <= FN_ALM3;
            if (mode_i.heat_cool && HAS_SECONDARY_CTRL_ROUTE) begin
                route_o.secondary_ctrl_route <= FN_COOL;
                route_o.aux_route_b <= FN_ALM2;
            end else if (mode_i.heat_cool) begin
                route_o.secondary_ctrl_route <= FN_NONE;
                route_o.aux_route_b <= FN_COOL;
            end else begin
                route_o.secondary_ctrl_route <= FN_NONE;
                route_o.aux_route_b <= FN_ALM2;
            end
        end else if (route_we_i && level_o == LVL_INIT) begin
            route_o <= route_i;
            if (!HAS_SECONDARY_CTRL_ROUTE)
                route_o.secondary_ctrl_route <= FN_NONE;
        end
    end

    // on/off: off at the set point, on again below sp minus hysteresis if reverse, above sp plus hysteresis if direct
    logic signed [PV_W:0] err;
    logic onoff_r;
    assign err = mode_o.direct ? ((PV_W+1)'(pv_i) - (PV_W+1)'(sp_i))
                               : ((PV_W+1)'(sp_i) - (PV_W+1)'(pv_i));
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            onoff_r <= 1'b0;
        else if (err <= 0)
            onoff_r <= 1'b0;
        else if (err > $signed({2'b00, hyst_i}))
            onoff_r <= 1'b1;
    end

    logic heat_pwm;
    logic cool_pwm;
    logic [7:0] cool_period;
    // cooling period only matters under heating/cooling
    assign cool_period = mode_o.heat_cool ? cool_ct_r : heat_ct_r;
    cycle_pwm #(.SEC_CYC(SEC_CYC)) u_heat_pwm (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .period_s_i(heat_ct_r),
        .mv_i(heat_mv_i),
        .pwm_o(heat_pwm)
    );
    cycle_pwm #(.SEC_CYC(SEC_CYC)) u_cool_pwm (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .period_s_i(cool_period),
        .mv_i(cool_mv_i),
        .pwm_o(cool_pwm)
    );

    logic heat_act;
    logic cool_act;
    assign heat_act = mode_o.on_off ? onoff_r : heat_pwm;
    assign cool_act = mode_o.on_off ? 1'b0 : cool_pwm;

    function automatic logic fn_val(input out_fn_t f, input logic lin,
                                    input logic pend);
        logic v;
        v = 1'b0;
        case (f)
            // linear outputs show the level, not a period
            FN_HEAT: v = lin ? (heat_mv_i != 7'h00) : heat_act;
            FN_COOL: v = lin ? (cool_mv_i != 7'h00) : cool_act;
            FN_ALM1: v = pend ? prog_end_i : alarm_i[0];
            FN_ALM2: v = alarm_i[1];
            FN_ALM3: v = alarm_i[2];
            FN_PEND: v = prog_end_i;
            FN_WORK: v = |work_i;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic is_alm(input out_fn_t f);
        return f == FN_ALM1 || f == FN_ALM2 || f == FN_ALM3 || f == FN_WORK;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl1_o <= 1'b0;
            ctrl2_o <= 1'b0;
            aux_o <= '0;
            alarm_assigned_o <= 1'b0;
        end else begin
            ctrl1_o <= fn_val(route_o.primary_ctrl_route, PRIMARY_CTRL_ROUTE_LINEAR, 1'b0);
            ctrl2_o <= HAS_SECONDARY_CTRL_ROUTE &&
                fn_val(route_o.secondary_ctrl_route, SECONDARY_CTRL_ROUTE_LINEAR, 1'b0);
            aux_o[0] <= fn_val(route_o.aux_route_a, 1'b0, pattern_on_i);
            aux_o[1] <= fn_val(route_o.aux_route_b, 1'b0, 1'b0);
            aux_o[2] <= fn_val(route_o.aux_route_c, 1'b0, 1'b0);
            alarm_assigned_o <= is_alm(route_o.primary_ctrl_route) ||
                is_alm(route_o.secondary_ctrl_route) ||
                is_alm(route_o.aux_route_a) || is_alm(route_o.aux_route_b) ||
                is_alm(route_o.aux_route_c);
        end
    end

    a_reset_defaults: assert property (@(posedge ref_clk_i)
        $past(rst_i) |-> !mode_o.unit_fahr && !mode_o.on_off &&
        !mode_o.direct && heat_ct_r == `CYCLE_TIME_RST &&
        cool_ct_r == `CYCLE_TIME_RST)
        else $error("reset defaults wrong");
    a_reset_route: assert property (@(posedge ref_clk_i)
        $past(rst_i) |-> route_o.primary_ctrl_route == FN_HEAT &&
        route_o.secondary_ctrl_route == FN_NONE &&
        route_o.aux_route_a == FN_ALM1 && route_o.aux_route_b == FN_ALM2 &&
        route_o.aux_route_c == FN_ALM3)
        else $error("reset routing wrong");
    a_enter_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(rst_i) && $rose(level_o == LVL_INIT) |->
        hold_r == CW'(HOLD_ENTER_CYC))
        else $error("entered setting level early");
    a_leave_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(rst_i) && $rose(level_o == LVL_OPER) |->
        hold_r == CW'(HOLD_LEAVE_CYC))
        else $error("left setting level early");
    a_no_positional: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) POSITIONAL |-> !mode_o.on_off)
        else $error("on/off on positional variant");
    a_onoff_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mode_o.on_off && !mode_o.direct && pv_i >= sp_i |=> !onoff_r)
        else $error("on/off output not off above sp");
    a_onoff_hyst: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !onoff_r && err <= $signed({2'b00, hyst_i}) |=> !onoff_r)
        else $error("on/off resumed inside hysteresis");
    a_cool_reroute: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        hc_chg && mode_i.heat_cool |=>
        (HAS_SECONDARY_CTRL_ROUTE ? route_o.secondary_ctrl_route == FN_COOL
                  : route_o.aux_route_b == FN_COOL))
        else $error("cooling not reassigned");
    a_prog_end: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pattern_on_i && route_o.aux_route_a == FN_ALM1 |=>
        aux_o[0] == $past(prog_end_i))
        else $error("program end not on aux one");
    a_work_alarm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        route_o.aux_route_c == FN_WORK |=> alarm_assigned_o)
        else $error("work bit not counted as alarm");
endmodule

// *** dv/load_model.sv ***
// heater and cooler loads hanging on the two control outputs
// assumes the outputs are registered levels on ref_clk_i
`timescale 1ns/1ps
module load_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic heater_i,
    input wire logic cooler_i,
    output logic [15:0] heat_on_o,
    output logic [15:0] cool_on_o
);
    // solid state loads, so periods under 20 s are tolerated here;
    // a relay load would want 20 s or more
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clr_i) begin
            heat_on_o <= 16'h0000;
            cool_on_o <= 16'h0000;
        end else begin
            heat_on_o <= heat_on_o + {15'h0000, heater_i};
            cool_on_o <= cool_on_o + {15'h0000, cooler_i};
        end
    end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the control output configuration block
// assumes short hold and second counts set through parameters
`timescale 1ns/1ps
module tb;
    import ctrl_out_pkg::*;
    typedef struct {int sel; logic [31:0] val;} note_t;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic level_key_i = 1'b0, cfg_we_i = 1'b0, route_we_i = 1'b0;
    mode_t mode_i = '0;
    logic [7:0] heat_cycle_time_i = 8'h14, cool_cycle_time_i = 8'h14;
    route_t route_i = '0;
    logic pattern_on_i = 1'b0, prog_end_i = 1'b0, clr = 1'b0;
    logic signed [15:0] pv_i = 16'sh0000, sp_i = 16'sh0064;
    logic [14:0] hyst_i = 15'h000A;
    logic [6:0] heat_mv_i = 7'h00, cool_mv_i = 7'h00;
    logic [2:0] alarm_i = 3'h0, work_i = 3'h0, aux_o;
    level_t level_o;
    mode_t mode_o;
    route_t route_o;
    logic alarm_assigned_o, ctrl1_o, ctrl2_o;
    logic [15:0] heat_on, cool_on;
    int err_total = 0, n_compared = 0;
    int seed = 32'h1d7ced2a;
    note_t notes[$];
    note_t cur;
    int pvs[5] = '{50, 150, 95, 85, 100};
    logic ons[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic [31:0] RT_DEF = {12'h000, FN_HEAT, FN_NONE, FN_ALM1,
        FN_ALM2, FN_ALM3};

    ctrl_out_cfg #(.HOLD_ENTER_CYC(60), .HOLD_LEAVE_CYC(20),
        .SEC_CYC(100)) ctrl_out_cfg_inst (
        .ref_clk_i, .rst_i, .level_key_i, .cfg_we_i, .mode_i,
        .heat_cycle_time_i, .cool_cycle_time_i, .route_we_i, .route_i,
        .pattern_on_i, .pv_i, .sp_i, .hyst_i, .heat_mv_i, .cool_mv_i,
        .alarm_i, .prog_end_i, .work_i, .level_o, .mode_o, .route_o,
        .alarm_assigned_o, .ctrl1_o, .ctrl2_o, .aux_o);
    load_model load_model_inst (.ref_clk_i, .rst_i, .clr_i(clr),
        .heater_i(ctrl1_o), .cooler_i(ctrl2_o), .heat_on_o(heat_on),
        .cool_on_o(cool_on));

    always #2.5 ref_clk_i = ~ref_clk_i;

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic note(input int sel, input logic [31:0] val);
        note_t n;
        n.sel = sel;
        n.val = val;
        notes.push_back(n);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] observe(input int sel);
        case (sel)
            0: return {30'h0, level_o};
            1: return {28'h0, mode_o};
            2: return {12'h000, route_o};
            3: return {31'h0, alarm_assigned_o};
            4: return {31'h0, ctrl1_o};
            5: return {31'h0, ctrl2_o};
            6: return {29'h0, aux_o};
            8: return {16'h0000, cool_on};
            default: return {16'h0000, heat_on};
        endcase
    endfunction
    task automatic hold_key(input int n);
        level_key_i = 1'b1;
        step(n);
        level_key_i = 1'b0;
        step(6);
    endtask
    task automatic write_cfg(input mode_t m, input logic [7:0] hp);
        mode_i = m;
        heat_cycle_time_i = hp;
        cool_cycle_time_i = hp;
        cfg_we_i = 1'b1;
        step(1);
        cfg_we_i = 1'b0;
        step(2);
    endtask
    task automatic write_route(input route_t r);
        route_i = r;
        route_we_i = 1'b1;
        step(1);
        route_we_i = 1'b0;
        step(2);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(negedge ref_clk_i) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            check(observe(cur.sel), cur.val);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        final_report();
    end

    initial begin
        step(10);
        rst_i = 1'b0;
        step(1);
        note(1, 32'h0);
        note(2, RT_DEF);
        note(4, 32'h0);
        write_cfg(4'hF, 8'h01);
        note(1, 32'h0);
        $display("test reset done");
        level_key_i = 1'b1;
        step(50);
        note(0, LVL_OPER);
        step(20);
        note(0, LVL_INIT);
        level_key_i = 1'b0;
        step(6);
        write_cfg(4'h2, 8'h01);
        note(1, 32'h2);
        note(2, {12'h000, FN_HEAT, FN_COOL, FN_ALM1, FN_ALM2, FN_ALM3});
        write_cfg(4'h0, 8'h01);
        note(2, RT_DEF);
        write_route({FN_HEAT, FN_NONE, FN_NONE, FN_NONE, FN_WORK});
        note(3, 32'h1);
        write_route({FN_HEAT, FN_NONE, FN_NONE, FN_NONE, FN_NONE});
        note(3, 32'h0);
        write_route({FN_HEAT, FN_NONE, FN_ALM1, FN_ALM2, FN_WORK});
        level_key_i = 1'b1;
        step(12);
        note(0, LVL_INIT);
        step(20);
        note(0, LVL_OPER);
        level_key_i = 1'b0;
        step(6);
        $display("test levels and routing done");
        heat_mv_i = 7'h32;
        cool_mv_i = 7'h50;
        // let the new level reach the pins before the count window opens
        step(2);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(200);
        note(7, 32'd100);
        note(5, 32'h0);
        $display("test time proportional done");
        for (int i = 0; i < 8; i++) begin
            alarm_i = 3'($random(seed));
            work_i = 3'($random(seed));
            prog_end_i = 1'($random(seed));
            pattern_on_i = i[2];
            step(2);
            note(6, {29'h0, |work_i, alarm_i[1],
                pattern_on_i ? prog_end_i : alarm_i[0]});
        end
        $display("test auxiliary done");
        hold_key(70);
        write_cfg(4'h2, 8'h01);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(200);
        note(8, 32'd160);
        note(7, 32'd100);
        $display("test cooling done");
        write_cfg(4'hC, 8'h01);
        note(1, 32'hC);
        hold_key(30);
        for (int i = 0; i < 5; i++) begin
            pv_i = 16'(pvs[i]);
            step(4);
            note(4, {31'h0, ons[i]});
        end
        $display("test on off done");
        hold_key(70);
        note(0, LVL_INIT);
        rst_i = 1'b1;
        step(2);
        rst_i = 1'b0;
        step(1);
        note(0, LVL_OPER);
        note(1, 32'h0);
        note(2, RT_DEF);
        $display("test mid reset done");
        step(3);
        final_report();
    end
endmodule
